// ---- src/mcsx_top.sv ----
// MCU control register, sleep state machine and two external interrupt pins.
// Assumes pins are synchronous inputs and the core pulses i_sleep_instr.
`timescale 1ns/100ps
module mcsx_top (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Core side
	input wire logic i_sleep_instr,
	input wire logic i_wdt_reset,
	input wire logic i_int_ack,
	output logic o_mem_pins_override,
	output logic [2:0] o_mem_access_cycles,
	output logic o_cpu_halt,
	output logic o_osc_stop,
	output logic o_wake,
	output logic [1:0] o_irq_req,
	// External pins
	input wire logic i_ext_irq_pin_a,
	input wire logic i_ext_irq_pin_b
);
	logic [7:0] ctrl_r;
	logic [2:0] mask_r;
	logic [1:0] pin_s1_r;
	logic [1:0] pin_s2_r;
	logic [1:0] pin_prev_r;
	logic [1:0] edge_pend_r;
	logic [1:0] req_nxt;
	logic [1:0] level_act;
	logic [1:0] edge_hit;
	logic [1:0] irq_req_r;
	logic wake_nxt;
	logic ack_r;
	mcsx_pkg::mcsx_state_t state_r;
	mcsx_pkg::mcsx_state_t state_nxt;

	////////////////////////////////////////////////////////////////////////
	// Register bus: one wait cycle on every access
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_avs_waitrequest <= 1'b1;
		end else begin
			o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~ack_r);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ctrl_r <= mcsx_pkg::CTRL_RESET;
			mask_r <= mcsx_pkg::MASK_RESET;
		end else if (i_avs_write & ack_r) begin
			if (i_avs_address == mcsx_pkg::ADDR_CTRL) begin
				ctrl_r <= i_avs_writedata[7:0];
			end
			if (i_avs_address == mcsx_pkg::ADDR_MASK) begin
				mask_r <= i_avs_writedata[2:0];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read & ~ack_r) begin
			case (i_avs_address)
				mcsx_pkg::ADDR_CTRL: o_avs_readdata <= {24'h00_0000, ctrl_r};
				mcsx_pkg::ADDR_MASK: o_avs_readdata <= {29'h0000_0000, mask_r};
				mcsx_pkg::ADDR_STAT: o_avs_readdata <= {27'h000_0000, state_r, irq_req_r};
				default: o_avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory interface controls
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_mem_pins_override <= 1'b0;
			o_mem_access_cycles <= mcsx_pkg::ACC_BASE_CYCLES;
		end else begin
			o_mem_pins_override <= ctrl_r[mcsx_pkg::BIT_MEM_EN];
			o_mem_access_cycles <= mcsx_pkg::ACC_BASE_CYCLES
				+ {2'b00, ctrl_r[mcsx_pkg::BIT_MEM_WAIT]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin sampling, works whatever drives the pin
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pin_s1_r <= 2'h3;
			pin_s2_r <= 2'h3;
			pin_prev_r <= 2'h3;
		end else begin
			pin_s1_r <= {i_ext_irq_pin_b, i_ext_irq_pin_a};
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_pin
			logic [1:0] sense;
			logic enabled;
			assign sense = (gi == 0) ? ctrl_r[mcsx_pkg::BIT_SENSE_A +: 2]
				: ctrl_r[mcsx_pkg::BIT_SENSE_B +: 2];
			assign enabled = mask_r[gi] & mask_r[mcsx_pkg::BIT_GLOBAL_EN];
			assign level_act[gi] = (sense == mcsx_pkg::SENSE_LOW) & ~pin_s2_r[gi];
			assign edge_hit[gi] = ((sense == mcsx_pkg::SENSE_FALL) & pin_prev_r[gi] & ~pin_s2_r[gi])
				| ((sense == mcsx_pkg::SENSE_RISE) & ~pin_prev_r[gi] & pin_s2_r[gi]);
			assign req_nxt[gi] = enabled & (level_act[gi] | edge_pend_r[gi] | edge_hit[gi]);
			always_ff @(posedge i_clk_sys) begin
				if (i_rst) begin
					edge_pend_r[gi] <= 1'b0;
				end else if (edge_hit[gi] & enabled) begin
					edge_pend_r[gi] <= 1'b1;
				end else if (i_int_ack | ~enabled) begin
					edge_pend_r[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			irq_req_r <= 2'h0;
		end else begin
			irq_req_r <= req_nxt;
		end
	end
	assign o_irq_req = irq_req_r;

	////////////////////////////////////////////////////////////////////////
	// Sleep control; a reset returns to run, core restarts at reset vector
	always_comb begin
		state_nxt = state_r;
		wake_nxt = 1'b0;
		case (state_r)
			mcsx_pkg::MCSX_RUN: begin
				if (i_sleep_instr & ctrl_r[mcsx_pkg::BIT_SLP_ALLOW]) begin
					state_nxt = ctrl_r[mcsx_pkg::BIT_SLP_DEPTH] ? mcsx_pkg::MCSX_PDOWN
						: mcsx_pkg::MCSX_IDLE;
				end
			end
			mcsx_pkg::MCSX_IDLE: begin
				if (|req_nxt | i_wdt_reset) begin
					state_nxt = mcsx_pkg::MCSX_RUN;
					wake_nxt = 1'b1;
				end
			end
			mcsx_pkg::MCSX_PDOWN: begin
				if (|(req_nxt & level_act) | i_wdt_reset) begin
					state_nxt = mcsx_pkg::MCSX_RUN;
					wake_nxt = 1'b1;
				end
			end
			default: state_nxt = mcsx_pkg::MCSX_RUN;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_r <= mcsx_pkg::MCSX_RUN;
			o_cpu_halt <= 1'b0;
			o_osc_stop <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			state_r <= state_nxt;
			o_cpu_halt <= state_nxt != mcsx_pkg::MCSX_RUN;
			o_osc_stop <= state_nxt == mcsx_pkg::MCSX_PDOWN;
			o_wake <= wake_nxt;
		end
	end
endmodule

// ---- src/mcsx_pkg.sv ----
// Constants for the MCU control, sleep and external interrupt block.
// Assumes one 100 MHz system clock and an Avalon-MM register bus.
// How it works
// - Memory enable bit hands address, data and strobe pins to the memory bus.
// - Wait bit adds one wait cycle to each external memory access.
// - Sleep instruction only sleeps when the sleep allow bit is set.
// - Depth bit zero selects idle, one selects power down, taken at sleep.
// - Pin request needs global enable and its own mask bit.
// - Pin B sense: low level, reserved, falling edge, rising edge.
// - Pin A sense in bits 1:0 uses the same encoding.
// - Pins are sampled before edge detection; pulses over one clock are caught.
// - Level mode keeps requesting while the pin stays low.
// - Enabled interrupt wakes core from idle, only a level one from power down; core resumes with state kept.
// - Reset during sleep wakes core to the reset vector.
// - Idle halts CPU only; interrupts and watchdog reset can wake it.
// - Wake from idle restarts execution immediately.
// - Power down stops oscillator; wakes on reset, watchdog or level interrupt.
// - Interrupts fire even when pins are driven as outputs.
// - Level requests are not latched.
package mcsx_pkg;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	localparam logic [3:0] ADDR_CMD = 4'hC;
	localparam int BIT_MEM_EN = 7;
	localparam int BIT_MEM_WAIT = 6;
	localparam int BIT_SLP_ALLOW = 5;
	localparam int BIT_SLP_DEPTH = 4;
	localparam int BIT_SENSE_B = 2;
	localparam int BIT_SENSE_A = 0;
	localparam int BIT_MASK_A = 0;
	localparam int BIT_MASK_B = 1;
	localparam int BIT_GLOBAL_EN = 2;
	localparam int BIT_CMD_SLEEP = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [1:0] SENSE_LOW = 2'h0;
	localparam logic [1:0] SENSE_RSVD = 2'h1;
	localparam logic [1:0] SENSE_FALL = 2'h2;
	localparam logic [1:0] SENSE_RISE = 2'h3;
	localparam logic [2:0] ACC_BASE_CYCLES = 3'h3;
	typedef enum logic [2:0] {
		MCSX_RUN = 3'b001,
		MCSX_IDLE = 3'b010,
		MCSX_PDOWN = 3'b100
	} mcsx_state_t;
endpackage

// ---- verification/mcsx_props.sv ----
// Checker for the control, sleep and pin interrupt block.
// Sees only the top ports; bound from the bench.
`timescale 1ns/100ps
module mcsx_props (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic o_avs_waitrequest,
	input wire logic i_sleep_instr,
	input wire logic i_wdt_reset,
	input wire logic o_mem_pins_override,
	input wire logic o_cpu_halt,
	input wire logic o_osc_stop,
	input wire logic o_wake,
	input wire logic [1:0] o_irq_req
);
	logic wr_ctrl;
	assign wr_ctrl = i_avs_write && !o_avs_waitrequest && i_avs_address == mcsx_pkg::ADDR_CTRL;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	property p_bus; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> ##[0:1] !o_avs_waitrequest; endproperty
	property p_ovr; wr_ctrl |=> ##1 o_mem_pins_override == $past(i_avs_writedata[7], 2); endproperty
	property p_slp; $rose(o_cpu_halt) |-> $past(i_sleep_instr); endproperty
	property p_osc; o_osc_stop |-> o_cpu_halt; endproperty
	property p_wk; $fell(o_cpu_halt) && !$past(i_rst) |-> o_wake; endproperty
	property p_one; o_wake |=> !o_wake; endproperty
	property p_wdt; o_cpu_halt && i_wdt_reset |=> !o_cpu_halt; endproperty
	property p_why; o_wake |-> $past(i_wdt_reset) || o_irq_req != 2'h0; endproperty
	a_bus: assert property (p_bus) else $error("no bus answer");
	a_ovr: assert property (p_ovr) else $error("override wrong");
	a_slp: assert property (p_slp) else $error("halt without sleep");
	a_osc: assert property (p_osc) else $error("osc stop while running");
	a_wk: assert property (p_wk) else $error("no wake pulse");
	a_one: assert property (p_one) else $error("wake too long");
	a_wdt: assert property (p_wdt) else $error("watchdog no wake");
	a_why: assert property (p_why) else $error("wake without cause");
	c_wake: cover property (o_wake);
	c_pdown: cover property ($rose(o_osc_stop));
	c_irq: cover property (o_irq_req == 2'h3);
endmodule

// ---- verification/mcsx_pin_src.sv ----
// Source model for the two external interrupt pins.
// Assumes bench commands change just after clock edges.
`timescale 1ns/100ps
module mcsx_pin_src (
	// Clock and commands
	input wire logic i_clk_sys,
	input wire logic [1:0] i_lvl,
	input wire logic [1:0] i_pulse,
	// Pins
	output logic [1:0] o_pins
);
	logic [1:0] pul_r = 2'h0;
	// A one-cycle command inverts the pin for two cycles
	always_ff @(posedge i_clk_sys) begin
		pul_r <= i_pulse;
		o_pins <= i_lvl ^ (i_pulse | pul_r);
	end
endmodule

// ---- verification/mcsx_top_tb.sv ----
// Bench for the control, sleep and pin interrupt block.
// Assumes the pin model and checker in this folder.
`timescale 1ns/100ps
module mcsx_top_tb;
	logic i_clk_sys = 1'b0, i_rst = 1'b1, i_avs_read = 1'b0, i_avs_write = 1'b0;
	logic o_avs_waitrequest, o_mem_pins_override, o_cpu_halt, o_osc_stop, o_wake;
	logic [3:0] i_avs_address = 4'h0;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, q;
	logic [2:0] o_mem_access_cycles;
	logic [1:0] o_irq_req, pins, lvl = 2'h3, pul = 2'h0;
	logic [2:0] ev = 3'h0;
	logic [15:0] seed = 16'hBEEB;
	int num_errors = 0, checked = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	mcsx_top u_mcsx_top (.*, .i_sleep_instr(ev[0]), .i_wdt_reset(ev[1]), .i_int_ack(ev[2]),
		.i_ext_irq_pin_a(pins[0]), .i_ext_irq_pin_b(pins[1]));
	mcsx_pin_src u_mcsx_pin_src (.i_clk_sys(i_clk_sys), .i_lvl(lvl), .i_pulse(pul), .o_pins(pins));
	function automatic logic [15:0] xs(input logic [15:0] x);
		x ^= x << 7;
		x ^= x >> 9;
		return x ^ (x << 8);
	endfunction
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n = 0;
		i_avs_write <= w;
		i_avs_read <= !w;
		i_avs_address <= a;
		i_avs_writedata <= d;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 20);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		@(posedge i_clk_sys);
		if (n == 20) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic fire(input logic [2:0] e);
		ev <= e;
		@(posedge i_clk_sys);
		ev <= 3'h0;
		@(posedge i_clk_sys);
	endtask
	initial begin
		repeat (4) @(posedge i_clk_sys);
		chk({o_avs_waitrequest, o_cpu_halt, o_irq_req, o_mem_access_cycles}, 7'h43);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		bus(0, mcsx_pkg::ADDR_CTRL, 0);
		chk(q, 0);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			bus(1, mcsx_pkg::ADDR_CTRL, {24'h0, seed[7:0]});
			bus(0, mcsx_pkg::ADDR_CTRL, 0);
			chk(q, {24'h0, seed[7:0]});
			chk(o_mem_pins_override, seed[7]);
			chk(o_mem_access_cycles, 3 + seed[6]);
		end
		bus(0, mcsx_pkg::ADDR_CMD, 0);
		chk(q, 0);
		$display("test regs done");
		for (int p = 0; p < 2; p++) begin
			for (int c = 0; c < 4; c++) begin
				bus(1, mcsx_pkg::ADDR_MASK, 0);
				bus(1, mcsx_pkg::ADDR_CTRL, 32'(c) << (2 * p));
				lvl[p] <= c[0] ^ c[1];
				bus(1, mcsx_pkg::ADDR_MASK, 32'h1 << p);
				repeat (4) @(posedge i_clk_sys);
				chk(o_irq_req, 0);
				bus(1, mcsx_pkg::ADDR_MASK, 32'h4 | (32'h1 << p));
				lvl[p] <= c[1];
				pul[p] <= c == 2;
				@(posedge i_clk_sys);
				pul[p] <= 1'b0;
				repeat (4) @(posedge i_clk_sys);
				chk(o_irq_req, 32'(c != 1) << p);
				repeat (8) @(posedge i_clk_sys);
				chk(o_irq_req, 32'(c != 1) << p);
				lvl[p] <= 1'b1;
				fire({c > 1, 2'h0});
				repeat (4) @(posedge i_clk_sys);
				chk(o_irq_req, 0);
			end
		end
		$display("test pins done");
		bus(1, mcsx_pkg::ADDR_MASK, 32'h5);
		bus(0, mcsx_pkg::ADDR_MASK, 0);
		chk(q, 32'h5);
		bus(1, mcsx_pkg::ADDR_CTRL, 0);
		fire(3'h1);
		chk(o_cpu_halt, 0);
		bus(1, mcsx_pkg::ADDR_CTRL, 32'h20);
		fire(3'h1);
		chk({o_cpu_halt, o_osc_stop}, 2'h2);
		bus(0, mcsx_pkg::ADDR_STAT, 0);
		chk(q, 32'h8);
		fire(3'h2);
		chk({o_cpu_halt, o_wake}, 2'h1);
		bus(1, mcsx_pkg::ADDR_CTRL, 32'h30);
		fire(3'h1);
		chk({o_cpu_halt, o_osc_stop}, 2'h3);
		lvl[0] <= 1'b0;
		for (int n = 0; n < 8 && o_cpu_halt !== 1'b0; n++) @(posedge i_clk_sys);
		chk({o_cpu_halt, o_irq_req}, 3'h1);
		lvl[0] <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		fire(3'h1);
		chk({o_cpu_halt, o_osc_stop}, 2'h3);
		i_rst <= 1'b1;
		@(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(posedge i_clk_sys);
		chk({o_cpu_halt, o_osc_stop, o_wake}, 3'h0);
		bus(0, mcsx_pkg::ADDR_CTRL, 0);
		chk(q, 0);
		$display("test sleep done");
		complete_run();
	end
endmodule
bind mcsx_top mcsx_props u_mcsx_props (.*);
